// >>> hw/pmusp_pkg.sv
// pmusp_pkg: constants, types and register map for the pmu strap and host pin block
// assumes a 200 MHz system clock and an axi4-lite register master
// How it works
// R1: request low means standby, request high means powered on; the code powers on only from a request rise in standby after capture.
// R2: setup strap high picks setup 1, low setup 2, floating setup 3.
// R3: the board holds the setup strap fixed or floating.
// R4: address strap high answers at 7F, floating 7C, low 7D.
// R5: the board holds the address strap fixed; the host uses the matching address.
// R6: alert is open drain, pulled low for an interrupt.
// R7: sda is sampled and driven only low.
// R8: scl is input only.
// R9: the serial port runs up to 400 kHz and reaches the registers.
// R10: both straps are sampled once after reset, before standby; the code samples them while already held in standby.
// R11: a rising request edge starts startup.
// R12: a falling request edge starts shutdown in reverse order.
// R13: an unmasked thermal event pulls alert low until the irq register is read.
// R14: a strap is a two-bit code; unknown codes mean floating.
package pmusp_pkg;

  // *****************************
  // strap codes
  // *****************************
  typedef enum logic [1:0] {
    PMUSP_STRAP_FLOAT = 2'h0,
    PMUSP_STRAP_LOW = 2'h1,
    PMUSP_STRAP_HIGH = 2'h2
  } pmusp_strap_type;

  localparam logic [6:0] PMUSP_ADDR_HIGH = 7'h7F;
  localparam logic [6:0] PMUSP_ADDR_FLOAT = 7'h7C;
  localparam logic [6:0] PMUSP_ADDR_LOW = 7'h7D;

  localparam logic [1:0] PMUSP_SETUP_1 = 2'h1;
  localparam logic [1:0] PMUSP_SETUP_2 = 2'h2;
  localparam logic [1:0] PMUSP_SETUP_3 = 2'h3;

  // *****************************
  // serial register file (8-bit)
  // *****************************
  localparam logic [7:0] PMUSP_SR_CTRL = 8'h00;
  localparam logic [7:0] PMUSP_SR_STATUS = 8'h01;
  localparam logic [7:0] PMUSP_SR_IRQ = 8'h02;
  localparam logic [7:0] PMUSP_SR_MASK = 8'h03;
  localparam logic [7:0] PMUSP_SR_SCRATCH = 8'h04;

  // *****************************
  // axi4-lite register map
  // *****************************
  localparam logic [7:0] PMUSP_AX_STATUS = 8'h00;
  localparam logic [7:0] PMUSP_AX_IRQ = 8'h04;
  localparam logic [7:0] PMUSP_AX_MASK = 8'h08;
  localparam logic [7:0] PMUSP_AX_EVENT = 8'h0C;
  localparam logic [7:0] PMUSP_AX_SEQLEN = 8'h10;

  localparam int PMUSP_IRQ_WARN = 0;
  localparam int PMUSP_IRQ_TSD = 1;
  localparam int PMUSP_IRQ_UP = 2;
  localparam int PMUSP_IRQ_DOWN = 3;
  localparam logic [3:0] PMUSP_MASK_RESET = 4'h0;
  localparam logic [15:0] PMUSP_SEQLEN_RESET = 16'h1388;
  localparam logic [7:0] PMUSP_CTRL_RESET = 8'h00;

  typedef enum logic [3:0] {
    PMUSP_PWR_STANDBY = 4'b0001,
    PMUSP_PWR_STARTUP = 4'b0010,
    PMUSP_PWR_IDLE = 4'b0100,
    PMUSP_PWR_SHUTDOWN = 4'b1000
  } pmusp_pwr_type;

  typedef struct packed {
    logic [2:0] strap_sel;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmusp_sreq_type;

  typedef struct packed {
    logic pulse;
    logic [7:0] addr;
  } pmusp_srd_type;

endpackage

// >>> hw/pmusp_sync.sv
// pmusp_sync: two flip-flop synchroniser for a bundle of pin levels
// assumes inputs come from outside the clk_i domain
`timescale 1ns/1ps
module pmusp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;

  // first stage is read only by the second
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stage1 <= '0;
      sync_o <= '0;
    end
    else
    begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule

// >>> hw/pmusp_i2c.sv
// pmusp_i2c: two-wire serial slave, byte register access
// assumes scl and sda already synchronised to clk_i; scl is never driven
`timescale 1ns/1ps
module pmusp_i2c (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [6:0] slave_addr_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_o,
  output logic wr_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic rd_o,
  input wire logic [7:0] rdata_i
);

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_ACK = 5'b00100,
    ST_RX = 5'b01000,
    ST_TX = 5'b10000
  } pmusp_i2c_state_type;

  pmusp_i2c_state_type state;
  logic scl_d;
  logic sda_d;
  logic [7:0] shift;
  logic [3:0] bitcnt;
  logic is_read;
  logic have_reg;
  logic ack_ok;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  assign scl_rise = scl_i && !scl_d;
  assign scl_fall = !scl_i && scl_d;
  assign start_seen = scl_i && scl_d && sda_d && !sda_i;
  assign stop_seen = scl_i && scl_d && !sda_d && sda_i;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl_i;
      sda_d <= sda_i;
    end
  end

  // edges found by oversampling, fine far above 400 kHz R9
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= ST_IDLE;
      shift <= 8'h00;
      bitcnt <= 4'h0;
      is_read <= 1'b0;
      have_reg <= 1'b0;
      ack_ok <= 1'b0;
      sda_oe_o <= 1'b0;
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      addr_o <= 8'h00;
      wdata_o <= 8'h00;
    end
    else
    begin
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      // step the pointer only after the write has landed at the old one
      if (wr_o)
      begin
        addr_o <= addr_o + 8'h01;
      end
      if (start_seen)
      begin
        state <= ST_ADDR;
        bitcnt <= 4'h0;
        have_reg <= 1'b0;
        sda_oe_o <= 1'b0;
      end
      else if (stop_seen)
      begin
        state <= ST_IDLE;
        sda_oe_o <= 1'b0;
      end
      else
      begin
        unique case (state)
          ST_IDLE:
          begin
            sda_oe_o <= 1'b0;
          end
          ST_ADDR, ST_RX:
          begin
            if (scl_rise)
            begin
              shift <= {shift[6:0], sda_i};
              bitcnt <= bitcnt + 4'h1;
            end
            else if (scl_fall && bitcnt == 4'h8)
            begin
              bitcnt <= 4'h0;
              if (state == ST_ADDR)
              begin
                ack_ok <= (shift[7:1] == slave_addr_i); // R4
                is_read <= shift[0];
                sda_oe_o <= (shift[7:1] == slave_addr_i); // R7
                if (shift[7:1] != slave_addr_i)
                begin
                  state <= ST_IDLE;
                end
                else
                begin
                  state <= ST_ACK;
                  if (shift[0])
                  begin
                    rd_o <= 1'b1;
                  end
                end
              end
              else
              begin
                sda_oe_o <= 1'b1;
                state <= ST_ACK;
                if (!have_reg)
                begin
                  addr_o <= shift;
                  have_reg <= 1'b1;
                end
                else
                begin
                  wdata_o <= shift;
                  wr_o <= 1'b1;
                end
              end
            end
          end
          ST_ACK:
          begin
            if (scl_fall)
            begin
              if (is_read)
              begin
                state <= ST_TX;
                shift <= rdata_i;
                sda_oe_o <= !rdata_i[7]; // R7
                bitcnt <= 4'h1;
              end
              else
              begin
                state <= ST_RX;
                sda_oe_o <= 1'b0;
              end
            end
          end
          ST_TX:
          begin
            if (scl_rise && bitcnt == 4'h9)
            begin
              if (sda_i)
              begin
                state <= ST_IDLE;
              end
              else
              begin
                rd_o <= 1'b1;
                addr_o <= addr_o + 8'h01;
              end
            end
            else if (scl_fall)
            begin
              if (bitcnt == 4'h9)
              begin
                shift <= rdata_i;
                sda_oe_o <= !rdata_i[7];
                bitcnt <= 4'h1;
              end
              else if (bitcnt == 4'h8)
              begin
                sda_oe_o <= 1'b0;
                bitcnt <= 4'h9;
              end
              else
              begin
                shift <= {shift[6:0], 1'b0};
                sda_oe_o <= !shift[6];
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          default:
          begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// >>> hw/pmusp_top.sv
// pmusp_top: strap decode, power-state sequencing, alert and serial slave
// assumes pins arrive asynchronously and an axi4-lite master on clk_i
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module pmusp_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] default_setup_strap_i,
  input wire logic [1:0] bus_address_strap_i,
  input wire logic power_request_i,
  input wire logic thermal_warn_i,
  input wire logic thermal_shutdown_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic alert_n_o,
  output logic alert_n_oe_o,
  output logic [1:0] setup_o,
  output logic powered_on_o,
  output logic [3:0] power_state_o,
  output logic irq_o,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // *****************************
  // pin synchronisers
  // *****************************
  logic [10:0] pins_sync;
  logic [1:0] def_s;
  logic [1:0] adr_s;
  logic req_s;
  logic warn_s;
  logic tsd_s;
  logic scl_s;
  logic sda_s;

  pmusp_sync #(.WIDTH(11)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({default_setup_strap_i, bus_address_strap_i, power_request_i, thermal_warn_i,
      thermal_shutdown_i, scl_i, sda_i, 2'h0}),
    .sync_o(pins_sync)
  );
  assign {def_s, adr_s, req_s, warn_s, tsd_s, scl_s, sda_s} = pins_sync[10:2];

  // *****************************
  // strap capture
  // *****************************
  pmusp_pkg::pmusp_strap_type def_strap;
  pmusp_pkg::pmusp_strap_type adr_strap;
  logic [1:0] capture_cnt;
  logic straps_done;
  logic [6:0] slave_addr;

  function automatic pmusp_pkg::pmusp_strap_type decode_strap(input logic [1:0] raw);
    unique case (raw)
      2'h2: decode_strap = pmusp_pkg::PMUSP_STRAP_HIGH;
      2'h1: decode_strap = pmusp_pkg::PMUSP_STRAP_LOW;
      default: decode_strap = pmusp_pkg::PMUSP_STRAP_FLOAT; // R14
    endcase
  endfunction

  // wait for synchroniser to fill, then sample once; straps assumed static R3 R5
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      capture_cnt <= 2'h0;
      straps_done <= 1'b0;
      def_strap <= pmusp_pkg::PMUSP_STRAP_FLOAT;
      adr_strap <= pmusp_pkg::PMUSP_STRAP_FLOAT;
    end
    else if (!straps_done)
    begin
      capture_cnt <= capture_cnt + 2'h1;
      if (capture_cnt == 2'h3)
      begin
        straps_done <= 1'b1; // R10
        def_strap <= decode_strap(def_s); // R14
        adr_strap <= decode_strap(adr_s);
      end
    end
  end

  always_comb
  begin
    unique case (def_strap)
      pmusp_pkg::PMUSP_STRAP_HIGH: setup_o = pmusp_pkg::PMUSP_SETUP_1; // R2
      pmusp_pkg::PMUSP_STRAP_LOW: setup_o = pmusp_pkg::PMUSP_SETUP_2;
      default: setup_o = pmusp_pkg::PMUSP_SETUP_3;
    endcase
    unique case (adr_strap)
      pmusp_pkg::PMUSP_STRAP_HIGH: slave_addr = pmusp_pkg::PMUSP_ADDR_HIGH; // R4
      pmusp_pkg::PMUSP_STRAP_LOW: slave_addr = pmusp_pkg::PMUSP_ADDR_LOW;
      default: slave_addr = pmusp_pkg::PMUSP_ADDR_FLOAT;
    endcase
  end

  // *****************************
  // power state
  // *****************************
  pmusp_pkg::pmusp_pwr_type pwr;
  logic req_d;
  logic [15:0] seq_cnt;
  logic [15:0] seq_len;
  logic ev_up;
  logic ev_down;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      req_d <= 1'b0;
      pwr <= pmusp_pkg::PMUSP_PWR_STANDBY;
      seq_cnt <= 16'h0000;
    end
    else
    begin
      req_d <= req_s;
      if (!straps_done)
      begin
        pwr <= pmusp_pkg::PMUSP_PWR_STANDBY;
      end
      else
      begin
        unique case (pwr)
          pmusp_pkg::PMUSP_PWR_STANDBY:
          begin
            if (req_s && !req_d)
            begin
              pwr <= pmusp_pkg::PMUSP_PWR_STARTUP; // R11
              seq_cnt <= 16'h0000;
            end
          end
          pmusp_pkg::PMUSP_PWR_STARTUP:
          begin
            if (!req_s)
            begin
              pwr <= pmusp_pkg::PMUSP_PWR_SHUTDOWN; // R12
              seq_cnt <= seq_len - seq_cnt;
            end
            else if (seq_cnt >= seq_len)
            begin
              pwr <= pmusp_pkg::PMUSP_PWR_IDLE;
            end
            else
            begin
              seq_cnt <= seq_cnt + 16'h0001;
            end
          end
          pmusp_pkg::PMUSP_PWR_IDLE:
          begin
            if (!req_s)
            begin
              pwr <= pmusp_pkg::PMUSP_PWR_SHUTDOWN; // R12
              seq_cnt <= 16'h0000;
            end
          end
          pmusp_pkg::PMUSP_PWR_SHUTDOWN:
          begin
            if (seq_cnt >= seq_len)
            begin
              pwr <= pmusp_pkg::PMUSP_PWR_STANDBY; // R1
            end
            else
            begin
              seq_cnt <= seq_cnt + 16'h0001;
            end
          end
          default:
          begin
            pwr <= pmusp_pkg::PMUSP_PWR_STANDBY;
          end
        endcase
      end
    end
  end

  assign ev_up = straps_done && req_s && !req_d;
  assign ev_down = straps_done && !req_s && req_d;
  assign power_state_o = pwr;
  assign powered_on_o = (pwr == pmusp_pkg::PMUSP_PWR_STARTUP) || (pwr == pmusp_pkg::PMUSP_PWR_IDLE); // R1

  // *****************************
  // serial slave and interrupt status
  // *****************************
  logic s_wr;
  logic s_rd;
  logic [7:0] s_addr;
  logic [7:0] s_wdata;
  logic [7:0] s_rdata;
  logic [7:0] ctrl;
  logic [3:0] irq_stat;
  logic [3:0] irq_mask;
  logic [3:0] events;
  logic warn_d;
  logic tsd_d;
  logic sda_oe;
  logic ax_irq_read;

  pmusp_i2c u_i2c (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .slave_addr_i(slave_addr),
    .scl_i(scl_s), // R8
    .sda_i(sda_s),
    .sda_oe_o(sda_oe),
    .wr_o(s_wr),
    .addr_o(s_addr),
    .wdata_o(s_wdata),
    .rd_o(s_rd),
    .rdata_i(s_rdata)
  );

  assign sda_o = 1'b0; // R7
  assign sda_oe_o = sda_oe;

  always_comb
  begin
    unique case (s_addr)
      pmusp_pkg::PMUSP_SR_CTRL: s_rdata = ctrl;
      pmusp_pkg::PMUSP_SR_STATUS: s_rdata = {2'h0, setup_o, pwr};
      pmusp_pkg::PMUSP_SR_IRQ: s_rdata = {4'h0, irq_stat};
      pmusp_pkg::PMUSP_SR_MASK: s_rdata = {4'h0, irq_mask};
      default: s_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl <= pmusp_pkg::PMUSP_CTRL_RESET;
    end
    else if (s_wr && s_addr == pmusp_pkg::PMUSP_SR_CTRL)
    begin
      ctrl <= s_wdata; // R9
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      warn_d <= 1'b0;
      tsd_d <= 1'b0;
    end
    else
    begin
      warn_d <= warn_s;
      tsd_d <= tsd_s;
    end
  end

  always_comb
  begin
    events = 4'h0;
    events[pmusp_pkg::PMUSP_IRQ_WARN] = warn_s && !warn_d;
    events[pmusp_pkg::PMUSP_IRQ_TSD] = tsd_s && !tsd_d;
    events[pmusp_pkg::PMUSP_IRQ_UP] = ev_up;
    events[pmusp_pkg::PMUSP_IRQ_DOWN] = ev_down;
  end

  // read clears, but a new event in the same cycle stays set R13
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      irq_stat <= 4'h0;
    end
    else if ((s_rd && s_addr == pmusp_pkg::PMUSP_SR_IRQ) || ax_irq_read)
    begin
      irq_stat <= events; // R13
    end
    else
    begin
      irq_stat <= irq_stat | events;
    end
  end

  assign irq_o = |(irq_stat & ~irq_mask);
  assign alert_n_o = 1'b0; // R6
  assign alert_n_oe_o = irq_o; // R6

  // *****************************
  // axi4-lite slave
  // *****************************
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign ax_irq_read = s_axi_arvalid && s_axi_arready && s_axi_araddr == pmusp_pkg::PMUSP_AX_IRQ;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      irq_mask <= pmusp_pkg::PMUSP_MASK_RESET;
      seq_len <= pmusp_pkg::PMUSP_SEQLEN_RESET;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_hold && w_hold)
      begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        if (aw_addr == pmusp_pkg::PMUSP_AX_MASK && w_strb[0])
        begin
          irq_mask <= w_data[3:0];
        end
        else if (aw_addr == pmusp_pkg::PMUSP_AX_SEQLEN)
        begin
          if (w_strb[0])
          begin
            seq_len[7:0] <= w_data[7:0];
          end
          if (w_strb[1])
          begin
            seq_len[15:8] <= w_data[15:8];
          end
        end
        else if (aw_addr != pmusp_pkg::PMUSP_AX_MASK)
        begin
          s_axi_bresp <= 2'h2;
        end
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      unique case (s_axi_araddr)
        pmusp_pkg::PMUSP_AX_STATUS: s_axi_rdata <= {23'h000000, straps_done, 2'h0, setup_o, pwr};
        pmusp_pkg::PMUSP_AX_IRQ: s_axi_rdata <= {28'h0000000, irq_stat};
        pmusp_pkg::PMUSP_AX_MASK: s_axi_rdata <= {28'h0000000, irq_mask};
        pmusp_pkg::PMUSP_AX_EVENT: s_axi_rdata <= {25'h0000000, slave_addr};
        pmusp_pkg::PMUSP_AX_SEQLEN: s_axi_rdata <= {16'h0000, seq_len};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// >>> verification/pmusp_sva.sv
// pmusp_sva: properties on the pin ports of pmusp_top
// assumes one clock domain, clk_i, with rst_i async high
`timescale 1ns/1ps
module pmusp_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] default_setup_strap_i,
  input wire logic power_request_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic alert_n_o,
  input wire logic alert_n_oe_o,
  input wire logic [1:0] setup_o,
  input wire logic powered_on_o,
  input wire logic [3:0] power_state_o,
  input wire logic irq_o
);
  // ****************
  // helpers
  // ****************
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [4:0] cnt;
  // saturates, so the hold check covers any run length
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      cnt <= 5'h00;
    else if (cnt != 5'h1F)
      cnt <= cnt + 5'h01;
  end
  function automatic logic [1:0] dec(input logic [1:0] c);
    return c == 2'h2 ? 2'h1 : (c == 2'h1 ? 2'h2 : 2'h3);
  endfunction
  // ****************
  // properties
  // ****************
  property p_state; $onehot(power_state_o); endproperty
  a_state: assert property (p_state) else $error("power state not one-hot");
  property p_on; powered_on_o == (power_state_o[1] || power_state_o[2]); endproperty
  a_on: assert property (p_on) else $error("powered flag wrong");
  property p_rq; (!power_request_i) [*5] |-> !$rose(power_state_o[1]); endproperty
  a_rq: assert property (p_rq) else $error("startup without request");
  property p_up; $rose(power_state_o[1]) |-> $past(power_state_o[0]); endproperty
  a_up: assert property (p_up) else $error("startup not from standby");
  property p_dn; $rose(power_state_o[0]) |-> $past(power_state_o[3]); endproperty
  a_dn: assert property (p_dn) else $error("standby not after shutdown");
  property p_dec; cnt == 5'h14 |-> setup_o == dec(default_setup_strap_i); endproperty
  a_dec: assert property (p_dec) else $error("setup decode wrong");
  property p_hold; cnt > 5'h14 |-> $stable(setup_o); endproperty
  a_hold: assert property (p_hold) else $error("setup changed after capture");
  property p_alert; !alert_n_o && alert_n_oe_o == irq_o; endproperty
  a_alert: assert property (p_alert) else $error("alert pin wrong");
  property p_sda; !sda_o && (!$changed(sda_oe_o) || !scl_i || !$past(scl_i, 2)); endproperty
  a_sda: assert property (p_sda) else $error("sda driven wrongly");
  c_up: cover property ($rose(power_state_o[1]));
  c_irq: cover property ($rose(irq_o));
  c_ack: cover property ($rose(sda_oe_o));
endmodule
bind pmusp_top pmusp_sva pmusp_sva_inst (.clk_i, .rst_i, .default_setup_strap_i, .power_request_i, .scl_i,
  .sda_o, .sda_oe_o, .alert_n_o, .alert_n_oe_o, .setup_o, .powered_on_o, .power_state_o, .irq_o);

// >>> verification/pmusp_host.sv
// pmusp_host: host controller model on the two-wire link
// assumes the bench resolves sda with a pull-up
`timescale 1ns/1ps
module pmusp_host (
  output logic scl_o,
  output logic sda_oe_o,
  input wire logic sda_i
);
  localparam time H = 24ns;
  logic [7:0] rb;
  event got;
  // clock stands high between frames
  initial
  begin
    scl_o = 1'h1;
    sda_oe_o = 1'h0;
  end
  // data moves a quarter after scl falls, never with it
  task automatic bt(input logic b, output logic r);
    #(H/2) sda_oe_o = ~b;
    #(H/2) scl_o = 1'h1;
    r = sda_i;
    #H scl_o = 1'h0;
  endtask
  task automatic by(input logic [7:0] d, output logic [7:0] r);
    logic k;
    for (int i = 7; i >= 0; i--)
    begin
      bt(d[i], k);
      r[i] = k;
    end
    bt(1'h1, k);
  endtask
  task automatic sta;
    #(H/2) sda_oe_o = 1'h0;
    #H scl_o = 1'h1;
    #H sda_oe_o = 1'h1;
    #H scl_o = 1'h0;
  endtask
  task automatic sto;
    #(H/2) sda_oe_o = 1'h1;
    #H scl_o = 1'h1;
    #H sda_oe_o = 1'h0;
    #H;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d);
    logic [7:0] r;
    sta;
    by({a, 1'h0}, r);
    by(p, r);
    by(d, r);
    sto;
  endtask
  // last byte is not acknowledged, which ends the read
  task automatic rd(input logic [6:0] a, input logic [7:0] p);
    sta;
    by({a, 1'h0}, rb);
    by(p, rb);
    sta;
    by({a, 1'h1}, rb);
    by(8'hFF, rb);
    sto;
    -> got;
  endtask
endmodule

// >>> verification/pmusp_top_tb.sv
// pmusp_top_tb: straps, power states, alert and both register paths
// assumes pmusp_host on the link and a pull-up on sda
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; $display("wrong value at %0t: %h not %h", $time, a, b); end end
module pmusp_top_tb;
  logic clk_i = 1'h0, rst_i = 1'h1, power_request_i = 1'h0, thermal_warn_i = 1'h0, thermal_shutdown_i = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [1:0] default_setup_strap_i = 2'h0, bus_address_strap_i = 2'h0, setup_o, s_axi_bresp, s_axi_rresp;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, sd = 32'hF5993807;
  logic [3:0] s_axi_wstrb = 4'hF, power_state_o;
  logic scl_i, sda_i, sda_o, sda_oe_o, alert_n_o, alert_n_oe_o, powered_on_o, irq_o, h_oe;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [33:0] q[$];
  logic [7:0] iq[$];
  int failures = 0, check_count = 0;
  always #2.5 clk_i = ~clk_i;
  assign sda_i = !(sda_oe_o || h_oe);
  pmusp_top pmusp_top_inst (.clk_i, .rst_i, .default_setup_strap_i, .bus_address_strap_i, .power_request_i,
    .thermal_warn_i, .thermal_shutdown_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .alert_n_o, .alert_n_oe_o,
    .setup_o, .powered_on_o, .power_state_o, .irq_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  pmusp_host pmusp_host_inst (.scl_o(scl_i), .sda_oe_o(h_oe), .sda_i(sda_i));
  function automatic logic [31:0] xs();
    sd ^= sd << 13;
    sd ^= sd >> 17;
    sd ^= sd << 5;
    return sd;
  endfunction
  task automatic end_sim;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    q.push_back({r, 32'h0});
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    fork
      begin
        do @(posedge clk_i); while (!s_axi_awready);
        s_axi_awvalid <= 1'h0;
      end
      begin
        do @(posedge clk_i); while (!s_axi_wready);
        s_axi_wvalid <= 1'h0;
      end
    join
    do @(posedge clk_i); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask
  task automatic axr(input logic [7:0] a, input logic [33:0] e);
    q.push_back(e);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk_i); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk_i); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask
  // ****************
  // result watchers
  // ****************
  always @(posedge clk_i)
  begin
    if (s_axi_rvalid && s_axi_rready)
      `CHK({s_axi_rresp, s_axi_rdata}, q.pop_front())
    else if (s_axi_bvalid && s_axi_bready)
      `CHK({s_axi_bresp, 32'h0}, q.pop_front())
  end
  always @(pmusp_host_inst.got)
    `CHK(pmusp_host_inst.rb, iq.pop_front())
  initial
  begin
    #300us;
    failures++;
    end_sim;
  end
  // ****************
  // tests
  // ****************
  initial
  begin
    logic [1:0] s;
    logic [6:0] ad;
    logic [7:0] d;
    for (int c = 0; c < 4; c++)
    begin
      rst_i <= 1'h1;
      default_setup_strap_i <= c[1:0];
      bus_address_strap_i <= 2'h3 - c[1:0];
      repeat (6) @(posedge clk_i);
      rst_i <= 1'h0;
      repeat (12) @(posedge clk_i);
      s = c == 2 ? 2'h1 : (c == 1 ? 2'h2 : 2'h3);
      ad = c == 1 ? 7'h7F : (c == 2 ? 7'h7D : 7'h7C);
      axr(8'h00, {2'h0, 23'h0, 1'h1, 2'h0, s, 4'h1});
      axr(8'h0C, {2'h0, 25'h0, ad});
      axr(8'h10, {18'h0, pmusp_pkg::PMUSP_SEQLEN_RESET});
      d = xs();
      pmusp_host_inst.wr(ad, pmusp_pkg::PMUSP_SR_CTRL, d);
      iq.push_back(d);
      pmusp_host_inst.rd(ad, pmusp_pkg::PMUSP_SR_CTRL);
      iq.push_back(8'hFF);
      pmusp_host_inst.rd(ad ^ 7'h01, pmusp_pkg::PMUSP_SR_CTRL);
      $display("test straps %0d done", c);
    end
    axw(8'h10, 32'h6, 2'h0);
    axw(8'h40, 32'h0, 2'h2);
    axr(8'h40, {2'h2, 32'h0});
    power_request_i <= 1'h1;
    wait (power_state_o === 4'h4);
    axr(8'h00, 34'h134);
    axr(8'h04, 34'h4);
    axw(8'h08, 32'h1, 2'h0);
    axr(8'h08, 34'h1);
    thermal_warn_i <= 1'h1;
    repeat (8) @(posedge clk_i);
    `CHK(irq_o, 1'h0)
    power_request_i <= 1'h0;
    wait (power_state_o === 4'h1);
    repeat (2) @(posedge clk_i);
    `CHK(alert_n_oe_o, 1'h1)
    axr(8'h04, 34'h9);
    `CHK(irq_o, 1'h0)
    axw(8'h08, 32'h0, 2'h0);
    thermal_warn_i <= 1'h0;
    thermal_shutdown_i <= 1'h1;
    repeat (8) @(posedge clk_i);
    `CHK(alert_n_oe_o, 1'h1)
    axr(8'h04, 34'h2);
    `CHK(irq_o, 1'h0)
    $display("test power and alert done");
    end_sim;
  end
endmodule
